// >>> logic/lmd_pkg.sv
// Shared constants for the multiplexed LCD drive selector, plus its frame timer.
// Assumes one 40 MHz clock and an active low asynchronous reset everywhere.
`timescale 1ns/1ps

// ==========================================================
// Package
package lmd_pkg;
   localparam int NUM_SEG = 44;
   localparam int NUM_BP = 4;
   localparam int NUM_ROWS = 8;
   localparam int BANK_ROWS = 4;
   localparam int LVL_W = 3;
   localparam int PTR_W = 6;
   localparam int BITS_PER_BYTE = 8;
   // Multiplex ratio codes
   localparam logic [1:0] MUX_STATIC = 2'h0;
   localparam logic [1:0] MUX_1_2 = 2'h1;
   localparam logic [1:0] MUX_1_4 = 2'h2;
   localparam logic [1:0] MUX_RST = MUX_1_4;
   // Bias parameter a: bias is 1/(1+a)
   localparam logic [1:0] BIAS_A_MIN = 2'h1;
   localparam logic [1:0] BIAS_A_RST = 2'h2;
   // Drive level indices, in steps of panel_drive_voltage/(1+a)
   localparam logic [LVL_W-1:0] LVL_ZERO = 3'h0;
   localparam logic [LVL_W-1:0] LVL_ONE = 3'h1;
   localparam logic [LVL_W-1:0] LVL_OFF_MUX = 3'h2;
   localparam logic [PTR_W-1:0] PTR_END = 6'h2c;
   // Slot timing
   localparam longint CLK_FREQ_HZ = 40000000;
   localparam longint SLOT_TIME_US = 1250;
   localparam longint US_PER_S = 1000000;
   localparam longint SLOT_CYCLES_CALC = (SLOT_TIME_US * CLK_FREQ_HZ) / US_PER_S;

   // Backplane phases per frame for a multiplex code
   function automatic logic [2:0] phases_of(input logic [1:0] mux);
      case (mux)
         MUX_STATIC: phases_of = 3'h1;
         MUX_1_2: phases_of = 3'h2;
         default: phases_of = 3'h4;
      endcase
   endfunction : phases_of

   // Highest drive level index: two levels in static, a+2 levels otherwise
   function automatic logic [LVL_W-1:0] top_of(input logic [1:0] mux, input logic [1:0] a);
      top_of = (mux == MUX_STATIC) ? LVL_ONE : (LVL_W'(a) + LVL_ONE);
   endfunction : top_of

   // Mirror a level for the inverted frame
   function automatic logic [LVL_W-1:0] flip(input logic [LVL_W-1:0] lvl, input logic [LVL_W-1:0] top,
                                             input logic pol);
      flip = pol ? (top - lvl) : lvl;
   endfunction : flip
endpackage : lmd_pkg

// ==========================================================
// Frame timer: equal slots, one per backplane phase
module lmd_frame_timer
   import lmd_pkg::*;
#(
   parameter int SLOT_CYCLES = int'(SLOT_CYCLES_CALC)
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [2:0] phases_i,
   output logic [1:0] slot_o,
   output logic polarity_o,
   output logic wrap_o
);
   logic [31:0] cnt_reg;
   logic tick;

   // Slot prescaler
   assign tick = (cnt_reg == 32'(SLOT_CYCLES - 1));
   assign wrap_o = tick && ({1'b0, slot_o} >= (phases_i - 3'h1));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= '0;
      end else if (tick) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 32'h1;
      end
   end

   // Slot counter, wraps at the active phase count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slot_o <= 2'h0;
      end else if (wrap_o) begin
         slot_o <= 2'h0;
      end else if (tick) begin
         slot_o <= slot_o + 2'h1;
      end
   end

   // Polarity flips every frame
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         polarity_o <= 1'b0;
      end else if (wrap_o) begin
         polarity_o <= ~polarity_o;
      end
   end
endmodule : lmd_frame_timer

// >>> logic/lmd_drive_selector.sv
// Backplane and segment drive level selector with display RAM and display register.
// Assumes decoded commands and data bytes arrive from same-clock logic, one per strobe.
// How it works
// - Bias and multiplex ratio commands set the selector's configuration.
// - Static mode uses one phase and two levels, segments fully on or off.
// - 1:2 mode cycles two phases per frame with selectable bias.
// - 1:4 mode cycles four phases, each on its own backplane.
// - Bias a of 1, 2, 3 gives three, four or five levels.
// - Exactly four backplane outputs, waveforms picked by multiplex mode.
// - In 1:2, backplane two copies zero and three copies one.
// - In static, all backplanes copy backplane zero.
// - Up to 44 segment outputs; unused ones simply left open.
// - Segment level comes from current phase and its display register bit.
// - Controller executes decoded commands and holds configuration state.
// - Incoming data fills RAM in the order of the active mode.
// - Display register stays stable during the frame it drives.
// - A one turns the element on, a zero turns it off.
// - Output bank choice picks the displayed bank, independent of input bank.
`timescale 1ns/1ps

module lmd_drive_selector
   import lmd_pkg::*;
#(
   parameter int SLOT_CYCLES = int'(SLOT_CYCLES_CALC)
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic bias_cmd_valid_i,
   input wire logic [1:0] bias_a_i,
   input wire logic multiplex_ratio_command_i,
   input wire logic [1:0] mux_mode_i,
   input wire logic bank_cmd_valid_i,
   input wire logic input_bank_choice_i,
   input wire logic output_bank_choice_i,
   input wire logic ptr_load_valid_i,
   input wire logic [PTR_W-1:0] ptr_i,
   input wire logic data_valid_i,
   input wire logic [7:0] data_i,
   output logic [LVL_W-1:0] backplane_out_0_o,
   output logic [LVL_W-1:0] backplane_out_1_o,
   output logic [LVL_W-1:0] backplane_out_2_o,
   output logic [LVL_W-1:0] backplane_out_3_o,
   output logic [NUM_SEG*LVL_W-1:0] segment_level_o,
   output logic [1:0] mux_mode_o,
   output logic [1:0] bias_a_o,
   output logic polarity_o
);
   // ==========================================================
   // Configuration state
   logic [1:0] mux_reg;
   logic [1:0] bias_reg;
   logic ibs_reg;
   logic obs_reg;
   logic [PTR_W-1:0] ptr_reg;
   logic [PTR_W-1:0] ptr_next;
   logic [NUM_ROWS-1:0][NUM_SEG-1:0] ram_reg;
   logic [BANK_ROWS-1:0][NUM_SEG-1:0] disp_reg;
   logic [1:0] slot;
   logic pol;
   logic wrap;
   logic [LVL_W-1:0] top;
   logic [LVL_W-1:0] sel_lvl_reg;
   logic [LVL_W-1:0] top_reg;

   // Commands update configuration
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mux_reg <= MUX_RST;
         bias_reg <= BIAS_A_RST;
         ibs_reg <= 1'b0;
         obs_reg <= 1'b0;
      end else begin
         if (bias_cmd_valid_i && (bias_a_i >= BIAS_A_MIN)) begin
            bias_reg <= bias_a_i;
         end
         if (multiplex_ratio_command_i && (mux_mode_i != 2'h3)) begin
            mux_reg <= mux_mode_i;
         end
         if (bank_cmd_valid_i) begin
            ibs_reg <= input_bank_choice_i;
            obs_reg <= output_bank_choice_i;
         end
      end
   end

   // ==========================================================
   // Data pointer and RAM filling
   always_comb begin
      logic [PTR_W:0] sum;
      sum = {1'b0, ptr_reg} + (PTR_W+1)'(BITS_PER_BYTE / int'(phases_of(mux_reg)));
      ptr_next = (sum >= {1'b0, PTR_END}) ? PTR_END : sum[PTR_W-1:0];
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr_reg <= '0;
      end else if (ptr_load_valid_i) begin
         ptr_reg <= (ptr_i > PTR_END) ? PTR_END : ptr_i;
      end else if (data_valid_i) begin
         ptr_reg <= ptr_next;
      end
   end

   // Byte bits, MSB first, go to rows then columns per mode
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      int rows;
      int col;
      int row;
      if (!rst_n_i) begin
         ram_reg <= '0;
      end else if (data_valid_i && !ptr_load_valid_i) begin
         rows = int'(phases_of(mux_reg));
         for (int i = 0; i < BITS_PER_BYTE; i++) begin
            col = int'(ptr_reg) + i / rows;
            row = int'(ibs_reg) * BANK_ROWS + i % rows;
            if (col < NUM_SEG) begin
               ram_reg[row][col] <= data_i[BITS_PER_BYTE-1-i];
            end
         end
      end
   end

   // ==========================================================
   // Frame timing and display register
   lmd_frame_timer #(.SLOT_CYCLES(SLOT_CYCLES)) u_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .phases_i(phases_of(mux_reg)),
      .slot_o(slot),
      .polarity_o(pol),
      .wrap_o(wrap)
   );

   // Snapshot of the output bank, taken only at frame boundary
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         disp_reg <= '0;
      end else if (wrap) begin
         for (int r = 0; r < BANK_ROWS; r++) begin
            disp_reg[r] <= ram_reg[int'(obs_reg) * BANK_ROWS + r];
         end
      end
   end

   // ==========================================================
   // Drive level outputs
   assign top = top_of(mux_reg, bias_reg);

   // Backplane levels: selected phase at top, others at one step
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      logic [LVL_W-1:0] lv [NUM_BP];
      logic [1:0] ph;
      if (!rst_n_i) begin
         backplane_out_0_o <= LVL_ZERO;
         backplane_out_1_o <= LVL_ZERO;
         backplane_out_2_o <= LVL_ZERO;
         backplane_out_3_o <= LVL_ZERO;
      end else begin
         for (int k = 0; k < NUM_BP; k++) begin
            case (mux_reg)
               MUX_STATIC: ph = 2'h0;
               MUX_1_2: ph = 2'(k % 2);
               default: ph = 2'(k);
            endcase
            lv[k] = flip((ph == slot) ? top : LVL_ONE, top, pol);
         end
         backplane_out_0_o <= lv[0];
         backplane_out_1_o <= lv[1];
         backplane_out_2_o <= lv[2];
         backplane_out_3_o <= lv[3];
      end
   end

   // Segment levels: on opposes the selected backplane
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      logic [LVL_W-1:0] off_lvl;
      if (!rst_n_i) begin
         segment_level_o <= '0;
      end else begin
         off_lvl = (mux_reg == MUX_STATIC) ? top : LVL_OFF_MUX;
         for (int j = 0; j < NUM_SEG; j++) begin
            segment_level_o[j*LVL_W +: LVL_W] <=
               flip(disp_reg[slot][j] ? LVL_ZERO : off_lvl, top, pol);
         end
      end
   end

   // Status and helper registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mux_mode_o <= MUX_RST;
         bias_a_o <= BIAS_A_RST;
         polarity_o <= 1'b0;
         top_reg <= LVL_ZERO;
         sel_lvl_reg <= LVL_ZERO;
      end else begin
         mux_mode_o <= mux_reg;
         bias_a_o <= bias_reg;
         polarity_o <= pol;
         top_reg <= top;
         sel_lvl_reg <= pol ? LVL_ZERO : top;
      end
   end

   // ==========================================================
   // Assertions
   sequence s_static_held;
      (mux_reg == MUX_STATIC) && ($past(mux_reg) == MUX_STATIC);
   endsequence
   sequence s_half_held;
      (mux_reg == MUX_1_2) && ($past(mux_reg) == MUX_1_2);
   endsequence

   property p_static_copy;
      @(posedge clk_i) disable iff (!rst_n_i) s_static_held |->
         (backplane_out_1_o == backplane_out_0_o) && (backplane_out_2_o == backplane_out_0_o) &&
         (backplane_out_3_o == backplane_out_0_o);
   endproperty
   a_static_copy: assert property (p_static_copy) else $error("static backplanes differ");

   property p_half_copy;
      @(posedge clk_i) disable iff (!rst_n_i) s_half_held |->
         (backplane_out_2_o == backplane_out_0_o) && (backplane_out_3_o == backplane_out_1_o);
   endproperty
   a_half_copy: assert property (p_half_copy) else $error("1:2 backplane copies wrong");

   property p_quad_onehot;
      @(posedge clk_i) disable iff (!rst_n_i)
         $past(rst_n_i) && (mux_reg == MUX_1_4) && ($past(mux_reg) == MUX_1_4) && (bias_reg == $past(bias_reg)) |->
         $onehot({backplane_out_0_o == sel_lvl_reg, backplane_out_1_o == sel_lvl_reg,
                  backplane_out_2_o == sel_lvl_reg, backplane_out_3_o == sel_lvl_reg});
   endproperty
   a_quad_onehot: assert property (p_quad_onehot) else $error("1:4 not one selected backplane");

   property p_level_range;
      @(posedge clk_i) disable iff (!rst_n_i) $past(rst_n_i) |->
         (backplane_out_0_o <= top_reg) && (backplane_out_3_o <= top_reg) &&
         (segment_level_o[LVL_W-1:0] <= top_reg);
   endproperty
   a_level_range: assert property (p_level_range) else $error("drive level above top");

   property p_static_two;
      @(posedge clk_i) disable iff (!rst_n_i) s_static_held |->
         (segment_level_o[LVL_W-1:0] <= LVL_ONE) && (backplane_out_0_o <= LVL_ONE);
   endproperty
   a_static_two: assert property (p_static_two) else $error("static uses more than two levels");

   property p_bias_cmd;
      @(posedge clk_i) disable iff (!rst_n_i) bias_cmd_valid_i && (bias_a_i != 2'h0) |=>
         (bias_reg == $past(bias_a_i)) ##1 (bias_a_o == $past(bias_a_i, 2));
   endproperty
   a_bias_cmd: assert property (p_bias_cmd) else $error("bias command not applied");

   property p_mux_cmd;
      @(posedge clk_i) disable iff (!rst_n_i) multiplex_ratio_command_i && (mux_mode_i != 2'h3) |=>
         (mux_reg == $past(mux_mode_i));
   endproperty
   a_mux_cmd: assert property (p_mux_cmd) else $error("multiplex command not applied");

   property p_disp_stable;
      @(posedge clk_i) disable iff (!rst_n_i) !wrap |=> $stable(disp_reg);
   endproperty
   a_disp_stable: assert property (p_disp_stable) else $error("display register changed mid frame");

   property p_ptr_step;
      @(posedge clk_i) disable iff (!rst_n_i) data_valid_i && !ptr_load_valid_i |=>
         (ptr_reg == $past(ptr_next)) && (ptr_reg <= PTR_END);
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("data pointer step wrong");

   property p_pol_toggle;
      @(posedge clk_i) disable iff (!rst_n_i) wrap |=> (pol != $past(pol)) ##1 (polarity_o == $past(pol));
   endproperty
   a_pol_toggle: assert property (p_pol_toggle) else $error("polarity did not alternate");

   property p_slot_bound;
      @(posedge clk_i) disable iff (!rst_n_i) $stable(mux_reg) && (slot != $past(slot)) |->
         ({1'b0, slot} < phases_of(mux_reg));
   endproperty
   a_slot_bound: assert property (p_slot_bound) else $error("slot beyond active phases");
endmodule : lmd_drive_selector

// >>> verification/lmd_panel_model.sv
// Panel stand-in: reports which backplane rows light segment zero.
// Assumes level indices and status outputs from the drive selector.
`timescale 1ns/1ps

// ==========================================================
// Panel model
module lmd_panel_model
   import lmd_pkg::*;
(
   input wire logic [NUM_BP*LVL_W-1:0] bp_i,
   input wire logic [LVL_W-1:0] seg_i,
   input wire logic [1:0] mux_i,
   input wire logic [1:0] bias_a_i,
   output logic [NUM_BP-1:0] lit_o
);
   logic [LVL_W-1:0] top;
   logic [LVL_W-1:0] lvl;

   // Element lights only with the full drive span across it
   always_comb begin
      top = (mux_i == MUX_STATIC) ? 3'h1 : {1'b0, bias_a_i} + 3'h1;
      lit_o = '0;
      lvl = '0;
      for (int i = 0; i < NUM_BP; i++) begin
         lvl = bp_i[i*LVL_W +: LVL_W];
         lit_o[i] = ((lvl > seg_i) ? lvl - seg_i : seg_i - lvl) == top;
      end
   end
endmodule : lmd_panel_model

// >>> verification/lmd_drive_selector_test.sv
// Self-checking bench for the drive selector with a panel model on its outputs.
// Assumes a short slot count so that whole frames pass quickly.
`timescale 1ns/1ps

// ==========================================================
// Bench top
module lmd_drive_selector_test;
   import lmd_pkg::*;
   localparam int SLOT = 8;
   logic clk_i, rst_n_i, bias_v, mux_v, bank_v, in_bank, out_bank, ptr_v, data_v, pol_o;
   logic [1:0] bias_a, mux_m, mux_o, bias_o;
   logic [PTR_W-1:0] ptr;
   logic [7:0] data;
   logic [LVL_W-1:0] bp0, bp1, bp2, bp3;
   logic [NUM_SEG*LVL_W-1:0] seg;
   logic [NUM_BP-1:0] lit;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;

   lmd_drive_selector #(.SLOT_CYCLES(SLOT)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .bias_cmd_valid_i(bias_v),
      .bias_a_i(bias_a), .multiplex_ratio_command_i(mux_v), .mux_mode_i(mux_m), .bank_cmd_valid_i(bank_v),
      .input_bank_choice_i(in_bank), .output_bank_choice_i(out_bank), .ptr_load_valid_i(ptr_v), .ptr_i(ptr),
      .data_valid_i(data_v), .data_i(data), .backplane_out_0_o(bp0), .backplane_out_1_o(bp1),
      .backplane_out_2_o(bp2), .backplane_out_3_o(bp3), .segment_level_o(seg), .mux_mode_o(mux_o),
      .bias_a_o(bias_o), .polarity_o(pol_o));
   lmd_panel_model panel_u (.bp_i({bp3, bp2, bp1, bp0}), .seg_i(seg[2:0]), .mux_i(mux_o), .bias_a_i(bias_o),
      .lit_o(lit));

   // Clock and hang guard
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         stop_test();
      end
   end

   // ==========================================================
   // Helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask : tick
   function automatic int nph(input logic [1:0] m);
      return (m == 2'h0) ? 1 : (m == 2'h1) ? 2 : 4;
   endfunction : nph
   function automatic logic [2:0] flv(input logic [2:0] l, input logic [2:0] t, input logic p);
      return p ? t - l : l;
   endfunction : flv
   function automatic logic [2:0] slv(input logic b, input logic [1:0] m, input logic [2:0] t, input logic p);
      return flv(b ? 3'h0 : (m == 2'h0 ? t : 3'h2), t, p);
   endfunction : slv
   task automatic set_cfg(input logic [1:0] m, input logic [1:0] a);
      mux_v = 1'b1;
      mux_m = m;
      bias_v = 1'b1;
      bias_a = a;
      tick(1);
      mux_v = 1'b0;
      bias_v = 1'b0;
      tick(2);
   endtask : set_cfg
   task automatic put(input logic [7:0] d);
      data_v = 1'b1;
      data = d;
      tick(1);
   endtask : put
   task automatic write_at(input logic [PTR_W-1:0] p, input logic [7:0] d);
      ptr_v = 1'b1;
      ptr = p;
      tick(1);
      ptr_v = 1'b0;
      put(d);
   endtask : write_at
   task automatic bank(input logic ib, input logic ob);
      bank_v = 1'b1;
      in_bank = ib;
      out_bank = ob;
      tick(1);
      bank_v = 1'b0;
      tick(1);
   endtask : bank
   // One look at the outputs: find the active phase, then judge every backplane level and segments 0, 1 and 43
   task automatic observe(input logic [1:0] m, a, input logic [3:0] c0, c1, c43, inout logic [3:0] seen,
                          inout logic [1:0] pols);
      logic [2:0] t;
      logic [2:0] b [4];
      logic p;
      int ph;
      int mi;
      t = (m == 2'h0) ? 3'h1 : {1'b0, a} + 3'h1;
      b = '{bp0, bp1, bp2, bp3};
      ph = -1;
      p = 1'b0;
      for (int i = 0; i < nph(m); i++) begin
         if (b[i] === t || b[i] === 3'h0) begin
            ph = i;
            p = (b[i] === 3'h0);
         end
      end
      check(ph >= 0, 1'b1, "no active phase");
      if (ph < 0) return;
      seen[ph] = 1'b1;
      pols[p] = 1'b1;
      check(pol_o, p, "polarity status");
      for (int i = 0; i < 4; i++) begin
         mi = (m == 2'h0) ? 0 : (m == 2'h1) ? i % 2 : i;
         check(b[i], flv(mi == ph ? t : 3'h1, t, p), "backplane");
      end
      check(seg[2:0], slv(c0[ph], m, t, p), "segment 0");
      check(seg[5:3], slv(c1[ph], m, t, p), "segment 1");
      check(seg[131:129], slv(c43[ph], m, t, p), "segment 43");
      check(lit[ph], c0[ph], "panel element");
   endtask : observe
   // Two frames settle, then two frames are watched cycle by cycle
   task automatic watch(input logic [1:0] m, a, input logic [3:0] c0, c1, c43);
      logic [3:0] seen;
      logic [1:0] pols;
      seen = '0;
      pols = '0;
      tick(nph(m) * SLOT * 2 + 4);
      check(mux_o, m, "mode status");
      check(bias_o, a, "bias status");
      repeat (nph(m) * SLOT * 2) begin
         observe(m, a, c0, c1, c43, seen, pols);
         tick(1);
      end
      check(seen, (4'h1 << nph(m)) - 4'h1, "phases");
      check(pols, 2'h3, "polarity");
   endtask : watch

   // ==========================================================
   // Scenarios
   task automatic test_reset();
      check(mux_o, MUX_1_4, "reset mode");
      check(bias_o, 2'h2, "reset bias");
      watch(2'h2, 2'h2, 4'h0, 4'h0, 4'h0);
      $display("test reset done");
   endtask : test_reset
   task automatic test_modes();
      logic [7:0] byt [3] = '{8'h7f, 8'h5a, 8'ha5};
      logic [3:0] e0 [3] = '{4'h0, 4'h2, 4'h5};
      logic [3:0] e1 [3] = '{4'h1, 4'h2, 4'ha};
      for (int m = 0; m < 3; m++) begin
         for (int a = 1; a < 4; a++) begin
            set_cfg(2'(m), 2'(a));
            write_at(6'h00, byt[m]);
            data_v = 1'b0;
            watch(2'(m), 2'(a), e0[m], e1[m], 4'h0);
         end
      end
      $display("test modes done");
   endtask : test_modes
   task automatic test_refused();
      set_cfg(2'h3, 2'h0);
      check(mux_o, 2'h2, "mode 3 taken");
      check(bias_o, 2'h3, "bias 0 taken");
      $display("test refused done");
   endtask : test_refused
   task automatic test_ptr_end();
      write_at(6'h2a, 8'hff);
      put(8'h00);
      // Point at column 0, then load and a byte together: the load wins
      ptr_v = 1'b1;
      ptr = 6'h00;
      data_v = 1'b0;
      tick(1);
      ptr = 6'h3f;
      data_v = 1'b1;
      data = 8'hff;
      tick(1);
      ptr_v = 1'b0;
      data = 8'h00;
      tick(1);
      data_v = 1'b0;
      watch(2'h2, 2'h3, 4'h5, 4'ha, 4'hf);
      $display("test pointer end done");
   endtask : test_ptr_end
   task automatic test_banks();
      set_cfg(2'h2, 2'h2);
      bank(1'b1, 1'b0);
      write_at(6'h00, 8'hff);
      data_v = 1'b0;
      watch(2'h2, 2'h2, 4'h5, 4'ha, 4'hf);
      bank(1'b1, 1'b1);
      watch(2'h2, 2'h2, 4'hf, 4'hf, 4'h0);
      $display("test banks done");
   endtask : test_banks

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // Main sequence
   initial begin
      {rst_n_i, bias_v, mux_v, bank_v, in_bank, out_bank, ptr_v, data_v} = '0;
      {bias_a, mux_m, ptr, data} = '0;
      tick(8);
      check({2'h0, bp0, bp1}, 8'h00, "backplanes in reset");
      check({2'h0, bp2, bp3}, 8'h00, "upper backplanes in reset");
      check({5'h0, seg[2:0]}, 8'h00, "segment in reset");
      rst_n_i = 1'b1;
      tick(1);
      test_reset();
      test_modes();
      test_refused();
      test_ptr_end();
      test_banks();
      stop_test();
   end
endmodule : lmd_drive_selector_test
